// ---- src/bcdadj_core.sv ----
// datapath for the packed bcd adjust and the operand decrement instructions
// Operation
// - bcd_adjust_op corrects accumulator after packed BCD addition into valid packed BCD.
// - upper nibble always gets the low-digit carry, then 6 more if above 9 or carry set.
// - decrement_operand_op subtracts one, updating carry, nibble carry, negative, excess, zero.
// - destination bit 0 writes accumulator; 1 writes back to operand register.
// - bank choice 0 uses common access bank; 1 uses bank_pointer bank.
// - bank choice 0, extended set, address up to 95: indexed literal offset.
`timescale 1ns/1ns
module bcdadj_core (
  input  wire logic                          i_clk,
  input  wire logic                          i_nrst,
  input  wire logic                          i_valid,
  input  wire bcdadj_pkg::bcdadj_op_t        i_op,
  input  wire bcdadj_pkg::bcdadj_ctx_t       i_ctx,
  output logic [7:0]                         o_acc,
  output bcdadj_pkg::bcdadj_flags_t          o_flags,
  output logic [7:0]                         o_result,
  output logic [bcdadj_pkg::ADDR_W-1:0]      o_eff_addr,
  output logic                               o_done
);

  logic [7:0]                    mem [0:(1 << bcdadj_pkg::ADDR_W) - 1];

  logic [7:0]                    acc_reg;
  logic [7:0]                    acc_next;
  bcdadj_pkg::bcdadj_flags_t     flags_reg;
  bcdadj_pkg::bcdadj_flags_t     flags_next;
  logic [7:0]                    result_reg;
  logic [7:0]                    result_next;
  logic [bcdadj_pkg::ADDR_W-1:0] eff_addr_reg;
  logic [bcdadj_pkg::ADDR_W-1:0] eff_addr_next;
  logic                          done_reg;
  logic                          done_next;
  logic                          mem_we;
  logic [7:0]                    mem_wdata;
  logic [bcdadj_pkg::ADDR_W-1:0] addr;
  logic [7:0]                    operand;
  logic [8:0]                    adj_word;
  logic [7:0]                    dec_val;
  bcdadj_pkg::bcdadj_flags_t     dec_flags;

  // map the 8-bit operand field to a full data address
  function automatic logic [bcdadj_pkg::ADDR_W-1:0] map_addr(
    input logic [7:0]              f,
    input logic                    bank_choice,
    input bcdadj_pkg::bcdadj_ctx_t ctx
  );
    logic [bcdadj_pkg::ADDR_W-1:0] a;
    a = {ctx.bank_pointer, f};
    if (!bank_choice) begin
      if (ctx.ext_en && (f <= bcdadj_pkg::LITERAL_LIMIT)) begin
        // base plus offset wraps within the data space, as the pointer does
        a = ctx.index_base + {4'h0, f};
      end else if (f < bcdadj_pkg::ACCESS_SPLIT) begin
        a = {bcdadj_pkg::ACCESS_LOW_BNK, f};
      end else begin
        a = {bcdadj_pkg::ACCESS_HI_BNK, f};
      end
    end
    return a;
  endfunction

  // returns {carry_out, adjusted byte}
  function automatic logic [8:0] bcd_adjust(
    input logic [7:0] w,
    input logic       carry_in,
    input logic       nib_in
  );
    logic [4:0] lo;
    logic [4:0] hi;
    logic       lo_c;
    lo = {1'b0, w[3:0]};
    if ((w[3:0] > bcdadj_pkg::BCD_MAX) || nib_in) begin
      lo = {1'b0, w[3:0]} + {1'b0, bcdadj_pkg::BCD_FIX};
    end
    lo_c = lo[4];
    hi = {1'b0, w[7:4]} + {4'h0, lo_c};
    if ((hi > {1'b0, bcdadj_pkg::BCD_MAX}) || carry_in) begin
      hi = hi + {1'b0, bcdadj_pkg::BCD_FIX};
    end
    // a carry already standing stays set: the sum exceeded 99 either way
    return {hi[4] | carry_in, hi[3:0], lo[3:0]};
  endfunction

  function automatic bcdadj_pkg::bcdadj_flags_t dec_status(input logic [7:0] f);
    bcdadj_pkg::bcdadj_flags_t s;
    logic [7:0] r;
    r = f - bcdadj_pkg::DEC_STEP;
    // carry and nibble carry read as no-borrow, as for any subtraction
    s.carry              = (f != 8'h00);
    s.nibble_carry       = (f[3:0] != 4'h0);
    s.zero               = (r == 8'h00);
    s.signed_excess_flag = (f == bcdadj_pkg::SIGNED_MIN);
    s.negative           = r[7];
    return s;
  endfunction

  // kinds that address the data store and so report an effective address
  function automatic logic uses_store(input bcdadj_pkg::bcdadj_kind_t k);
    logic hit;
    case (k)
      bcdadj_pkg::BCDADJ_OP_WRITE: begin
        hit = 1'b1;
      end
      bcdadj_pkg::BCDADJ_OP_READ: begin
        hit = 1'b1;
      end
      bcdadj_pkg::BCDADJ_OP_DECR: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // idle and unused kind codes are refused, so a stray code never pulses done
  function automatic logic known_kind(input bcdadj_pkg::bcdadj_kind_t k);
    logic ok;
    case (k)
      bcdadj_pkg::BCDADJ_OP_LOAD_ACC: begin
        ok = 1'b1;
      end
      bcdadj_pkg::BCDADJ_OP_WRITE: begin
        ok = 1'b1;
      end
      bcdadj_pkg::BCDADJ_OP_READ: begin
        ok = 1'b1;
      end
      bcdadj_pkg::BCDADJ_OP_ADJUST: begin
        ok = 1'b1;
      end
      bcdadj_pkg::BCDADJ_OP_DECR: begin
        ok = 1'b1;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  assign addr      = map_addr(i_op.addr, i_op.bank_choice, i_ctx);
  assign operand   = mem[addr];
  assign adj_word  = bcd_adjust(acc_reg, flags_reg.carry, flags_reg.nibble_carry);
  assign dec_val   = operand - bcdadj_pkg::DEC_STEP;
  assign dec_flags = dec_status(operand);

  always_comb begin
    acc_next      = acc_reg;
    flags_next    = flags_reg;
    result_next   = result_reg;
    eff_addr_next = eff_addr_reg;
    done_next     = 1'b0;
    mem_we        = 1'b0;
    mem_wdata     = operand;
    if (i_valid) begin
      done_next = known_kind(i_op.kind);
      if (uses_store(i_op.kind)) begin
        eff_addr_next = addr;
      end
      case (i_op.kind)
        bcdadj_pkg::BCDADJ_OP_LOAD_ACC: begin
          acc_next    = i_op.literal;
          flags_next  = i_op.flags;
          result_next = i_op.literal;
        end
        bcdadj_pkg::BCDADJ_OP_WRITE: begin
          mem_we        = 1'b1;
          mem_wdata     = i_op.literal;
          result_next   = i_op.literal;
        end
        bcdadj_pkg::BCDADJ_OP_READ: begin
          result_next   = operand;
        end
        bcdadj_pkg::BCDADJ_OP_ADJUST: begin
          acc_next         = adj_word[7:0];
          flags_next.carry = adj_word[8];
          result_next      = adj_word[7:0];
        end
        bcdadj_pkg::BCDADJ_OP_DECR: begin
          flags_next    = dec_flags;
          result_next   = dec_val;
          if (i_op.dest) begin
            mem_we    = 1'b1;
            mem_wdata = dec_val;
          end else begin
            acc_next = dec_val;
          end
        end
        default: begin
          done_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      acc_reg      <= bcdadj_pkg::ACC_RESET;
      flags_reg    <= bcdadj_pkg::FLAGS_RESET;
      result_reg   <= bcdadj_pkg::ACC_RESET;
      eff_addr_reg <= bcdadj_pkg::ADDR_RESET;
      done_reg     <= 1'b0;
    end else begin
      acc_reg      <= acc_next;
      flags_reg    <= flags_next;
      result_reg   <= result_next;
      eff_addr_reg <= eff_addr_next;
      done_reg     <= done_next;
    end
  end

  // data store keeps its contents across reset, like the real file
  always_ff @(posedge i_clk) begin
    if (i_nrst && mem_we) begin
      mem[addr] <= mem_wdata;
    end
  end

  assign o_acc      = acc_reg;
  assign o_flags    = flags_reg;
  assign o_result   = result_reg;
  assign o_eff_addr = eff_addr_reg;
  assign o_done     = done_reg;

endmodule

// ---- src/bcdadj_pkg.sv ----
// shared types and constants for the bcd adjust / decrement datapath
package bcdadj_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;

  // operand addressing
  localparam logic [7:0]        ACCESS_SPLIT   = 8'h80;
  localparam logic [7:0]        LITERAL_LIMIT  = 8'h5F;
  localparam logic [3:0]        ACCESS_LOW_BNK = 4'h0;
  localparam logic [3:0]        ACCESS_HI_BNK  = 4'hF;

  // decimal adjust constants
  localparam logic [3:0]        BCD_MAX        = 4'h9;
  localparam logic [3:0]        BCD_FIX        = 4'h6;

  // decrement constants
  localparam logic [7:0]        DEC_STEP       = 8'h01;
  localparam logic [7:0]        SIGNED_MIN     = 8'h80;

  // reset values
  localparam logic [7:0]        ACC_RESET      = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET     = 12'h000;

  typedef enum logic [2:0] {
    BCDADJ_OP_IDLE     = 3'b000,
    BCDADJ_OP_LOAD_ACC = 3'b001,
    BCDADJ_OP_WRITE    = 3'b011,
    BCDADJ_OP_READ     = 3'b010,
    BCDADJ_OP_ADJUST   = 3'b110,
    BCDADJ_OP_DECR     = 3'b111
  } bcdadj_kind_t;

  typedef struct packed {
    logic carry;
    logic nibble_carry;
    logic zero;
    logic signed_excess_flag;
    logic negative;
  } bcdadj_flags_t;

  localparam bcdadj_flags_t FLAGS_RESET = '0;

  typedef struct packed {
    bcdadj_kind_t  kind;
    logic [7:0]    addr;
    logic          dest;
    logic          bank_choice;
    logic [7:0]    literal;
    bcdadj_flags_t flags;
  } bcdadj_op_t;

  typedef struct packed {
    logic [3:0]        bank_pointer;
    logic              ext_en;
    logic [ADDR_W-1:0] index_base;
  } bcdadj_ctx_t;

endpackage

// ---- verification/bcdadj_checker.sv ----
// concurrent checks on the ports of the bcd adjust and decrement datapath
`timescale 1ns/1ns
module bcdadj_checker (
  input wire logic                          i_clk,
  input wire logic                          i_nrst,
  input wire logic                          i_valid,
  input wire bcdadj_pkg::bcdadj_op_t        i_op,
  input wire bcdadj_pkg::bcdadj_ctx_t       i_ctx,
  input wire logic [7:0]                    o_acc,
  input wire bcdadj_pkg::bcdadj_flags_t     o_flags,
  input wire logic [7:0]                    o_result,
  input wire logic [bcdadj_pkg::ADDR_W-1:0] o_eff_addr,
  input wire logic                          o_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_adj; i_valid && i_op.kind == bcdadj_pkg::BCDADJ_OP_ADJUST; endsequence
  sequence s_dec; i_valid && i_op.kind == bcdadj_pkg::BCDADJ_OP_DECR; endsequence
  property p_done; ##1 o_done == $past(i_valid && i_op.kind != bcdadj_pkg::BCDADJ_OP_IDLE); endproperty
  a_done: assert property (p_done) else $error("done pulse mismatch");
  property p_adj_keep; s_adj |=> o_acc == o_result && o_flags[3:0] == $past(o_flags[3:0]); endproperty
  a_adj_keep: assert property (p_adj_keep) else $error("adjust touched other flags");
  property p_adj_carry; s_adj ##0 o_flags.carry |=> o_flags.carry; endproperty
  a_adj_carry: assert property (p_adj_carry) else $error("adjust lost carry");
  property p_adj_low; s_adj ##0 (o_acc[3:0] <= bcdadj_pkg::BCD_MAX && !o_flags.nibble_carry)
    |=> o_acc[3:0] == $past(o_acc[3:0]);
  endproperty
  a_adj_low: assert property (p_adj_low) else $error("adjust changed a valid low digit");
  property p_dec_acc; s_dec ##0 !i_op.dest |=> o_acc == o_result && o_flags.zero == (o_result == 8'h00)
    && o_flags.negative == o_result[7]; endproperty
  a_dec_acc: assert property (p_dec_acc) else $error("decrement to accumulator wrong");
  property p_dec_mem; s_dec ##0 i_op.dest |=> o_acc == $past(o_acc); endproperty
  a_dec_mem: assert property (p_dec_mem) else $error("write-back decrement changed accumulator");
  property p_bank; s_dec ##0 i_op.bank_choice |=> o_eff_addr == {$past(i_ctx.bank_pointer), $past(i_op.addr)};
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");
  property p_lit; s_dec ##0 (!i_op.bank_choice && i_ctx.ext_en && i_op.addr <= bcdadj_pkg::LITERAL_LIMIT)
    |=> o_eff_addr == $past(i_ctx.index_base) + 12'($past(i_op.addr)); endproperty
  a_lit: assert property (p_lit) else $error("indexed address wrong");
endmodule

// ---- verification/tb_bcd_adjust_and_decrement.sv ----
// self-checking testbench for the bcd adjust and decrement datapath
`timescale 1ns/1ns
module tb_bcd_adjust_and_decrement;
  logic                      i_clk, i_nrst, i_valid;
  bcdadj_pkg::bcdadj_op_t    i_op;
  bcdadj_pkg::bcdadj_ctx_t   i_ctx;
  bcdadj_pkg::bcdadj_flags_t o_flags, fl;
  logic [7:0]                o_acc, o_result, lfsr, v, f, r, x, acc_e;
  logic [11:0]               o_eff_addr;
  logic [8:0]                e;
  logic                      o_done, d, a;
  int                        errors, checked;

  bcdadj_core dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(i_valid), .i_op(i_op), .i_ctx(i_ctx),
    .o_acc(o_acc), .o_flags(o_flags), .o_result(o_result), .o_eff_addr(o_eff_addr), .o_done(o_done));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  function logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction

  function logic [8:0] daa(input logic [7:0] w, input logic c, nc);
    logic [8:0] t;
    t = {1'b0, w};
    if (w[3:0] > 4'h9 || nc) t = t + 9'h006;
    if (t[8:4] > 5'h09 || c) t = t + 9'h060;
    t[8] = t[8] | c;
    return t;
  endfunction

  function logic [11:0] ea(input logic ab, input logic [7:0] fa);
    if (ab) return {i_ctx.bank_pointer, fa};
    if (i_ctx.ext_en && fa <= 8'h5F) return i_ctx.index_base + 12'(fa);
    return {fa[7] ? 4'hF : 4'h0, fa};
  endfunction

  task chk(input logic [11:0] got, exp, input string m);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask

  task chk_reset();
    chk(12'(o_acc), 12'(bcdadj_pkg::ACC_RESET), "reset accumulator");
    chk(12'(o_flags), 12'(bcdadj_pkg::FLAGS_RESET), "reset flags");
    chk(12'(o_result), 12'(bcdadj_pkg::ACC_RESET), "reset result");
    chk(o_eff_addr, bcdadj_pkg::ADDR_RESET, "reset address");
    chk(12'(o_done), 12'h000, "reset done");
  endtask

  task run(input bcdadj_pkg::bcdadj_kind_t k, input logic [7:0] fa, input logic dd, ab, input logic [7:0] lit,
           input bcdadj_pkg::bcdadj_flags_t fi);
    @(posedge i_clk);
    #1 i_valid = 1'b1;
    i_op = '{k, fa, dd, ab, lit, fi};
    @(posedge i_clk);
    #1 i_valid = 1'b0;
    chk(12'(o_done), 12'h001, "done missing");
  endtask

  task summarize();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #50000;
    errors++;
    summarize();
  end

  initial begin
    lfsr = 8'h45;
    i_nrst = 1'b0;
    i_valid = 1'b0;
    i_op = '0;
    i_ctx = '0;
    repeat (5) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    chk_reset();
    for (int i = 0; i < 60; i++) begin
      v = (i == 0) ? 8'hA5 : rnd();
      x = rnd();
      fl = (i == 0) ? '0 : x[4:0];
      run(bcdadj_pkg::BCDADJ_OP_LOAD_ACC, 8'h00, 1'b0, 1'b0, v, fl);
      run(bcdadj_pkg::BCDADJ_OP_ADJUST, 8'h00, 1'b0, 1'b0, 8'h00, '0);
      e = daa(v, fl.carry, fl.nibble_carry);
      chk(12'(o_acc), 12'(e[7:0]), "adjusted value");
      chk(12'(o_flags), 12'({e[8], fl[3:0]}), "adjust flags");
    end
    acc_e = o_acc;
    // an idle kind with valid high is refused: no done, no state change
    @(posedge i_clk);
    #1 i_valid = 1'b1;
    i_op = '{bcdadj_pkg::BCDADJ_OP_IDLE, 8'h00, 1'b0, 1'b0, 8'h3C, '1};
    @(posedge i_clk);
    #1 i_valid = 1'b0;
    chk(12'(o_done), 12'h000, "idle kind answered");
    chk(12'(o_acc), 12'(acc_e), "idle kind changed accumulator");
    // reset in mid-run clears every output register
    @(posedge i_clk);
    #1 i_nrst = 1'b0;
    @(posedge i_clk);
    #1 i_nrst = 1'b1;
    chk_reset();
    acc_e = bcdadj_pkg::ACC_RESET;
    for (int i = 0; i < 60; i++) begin
      v = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : (i == 2) ? 8'h00 : rnd();
      f = rnd();
      x = rnd();
      a = x[0];
      d = x[1];
      i_ctx = {x[7:4], x[2], rnd(), f[3:0]};
      run(bcdadj_pkg::BCDADJ_OP_WRITE, f, 1'b0, a, v, '0);
      run(bcdadj_pkg::BCDADJ_OP_DECR, f, d, a, 8'h00, '0);
      r = v - 8'h01;
      if (!d) acc_e = r;
      chk(o_eff_addr, ea(a, f), "effective address");
      chk(12'(o_result), 12'(r), "decrement result");
      chk(12'(o_flags), 12'({v != 8'h00, v[3:0] != 4'h0, r == 8'h00, v == 8'h80, r[7]}), "decr flags");
      chk(12'(o_acc), 12'(acc_e), "accumulator");
      run(bcdadj_pkg::BCDADJ_OP_READ, f, 1'b0, a, 8'h00, '0);
      chk(12'(o_result), 12'(d ? r : v), "stored operand");
    end
    summarize();
  end
endmodule

bind bcdadj_core bcdadj_checker u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_valid(i_valid), .i_op(i_op),
  .i_ctx(i_ctx), .o_acc(o_acc), .o_flags(o_flags), .o_result(o_result), .o_eff_addr(o_eff_addr), .o_done(o_done));
